// ---- src/doc_defs.svh ----
/*
  constants of the drive output conditioning block: register map, reset
  values, setting ranges, scales and time bases.
  assumes a 40 MHz pclk and a 32-bit APB register bus.
*/
`ifndef DOC_DEFS_SVH
`define DOC_DEFS_SVH

// ==========================================================
// register word indices (byte address = index * 4)
`define DOC_IX_PF_SRC 4'h0
`define DOC_IX_AO1_SRC 4'h1
`define DOC_IX_AO2_SRC 4'h2
`define DOC_IX_PF_MAX 4'h3
`define DOC_IX_AO1_OFS 4'h4
`define DOC_IX_AO1_GAIN 4'h5
`define DOC_IX_AO2_OFS 4'h6
`define DOC_IX_AO2_GAIN 4'h7
`define DOC_IX_DLY_FIRST 4'h8
`define DOC_IX_DLY_LAST 4'hC
`define DOC_IX_POLARITY 4'hD
`define DOC_IX_PF_STATUS 4'hE
`define DOC_IX_SW_STATUS 4'hF
`define DOC_NUM_CFG 14

// ==========================================================
// reset values
`define DOC_RST_AO2_SRC 16'h0001
`define DOC_RST_PF_MAX 16'h1388
`define DOC_RST_GAIN 16'h0064
`define DOC_RST_ZERO 16'h0000

// ==========================================================
// setting ranges
`define DOC_SRC_MAX 16'h0010
`define DOC_PF_MIN 16'h0001
`define DOC_PF_LIMIT 16'h2710
`define DOC_COEF_LIMIT 16'h03E8
`define DOC_DLY_LIMIT 16'h8CA0

// ==========================================================
// scales: 0.1 % steps, 0.01 units for gain, 0.001 % analog level
`define DOC_PCT_FULL 32'h0000_03E8
`define DOC_PCT_SAT 11'h3E8
`define DOC_OFS_SCALE 32'h0000_0064
`define DOC_AO_FULL 32'h0001_86A0
`define DOC_FS_PULSE_IN 32'h0000_2710
`define DOC_FS_AIN 32'h0000_03E8
`define DOC_FS_CURRENT_A 32'h0000_2710
`define DOC_FS_VOLT_V 32'h0000_2710
`define DOC_DIV_STEPS 6'h20

// ==========================================================
// time bases
`define DOC_CLK_HZ 40000000
`define DOC_CLK_PERIOD_NS 25
`define DOC_PF_STEP_HZ 10
`define DOC_DLY_UNIT_NS 100000000

`endif

// ---- src/doc_pkg.sv ----
/*
  types of the drive output conditioning block.
  used by doc_top only; constants stand in doc_defs.svh.
*/
package doc_pkg;

  // ==========================================================
  // scaler sequencer states
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_DIV = 3'b010,
    ST_STORE = 3'b100
  } doc_state_t;

  typedef logic [15:0] doc_word_t;

endpackage : doc_pkg

// ---- src/doc_top.sv ----
/*
  drive output conditioning: source selection and scaling for the pulse
  output and two analog outputs, gain/offset correction, switched output
  delay and polarity, APB register file.
  assumes quantities from the drive core are synchronous to pclk and
  that the analog converters take a 0..100000 code for 0..10 V / 20 mA.
*/
// Register access over APB and the placing of the registers were chosen for this implementation.
// Function
// R1: pulse output runs from 0.01 kHz up to the programmed maximum.
// R2: maximum pulse frequency accepts 0.01..100.00 kHz, resets to 50.00 kHz.
// R3: each output maps its source to 0..100 %; codes 0,1 use max frequency.
// R4: codes 2,3,4 reach full scale at twice rated current, torque, power.
// R5: code 5 reaches full scale at 1.2 times rated drive voltage.
// R6: code 16 spans -2..+2 rated torque; code 14 spans 0..1000.0 A.
// R7: codes 10, 11 scale to maximum length and maximum count.
// R8: code 13 scales to the speed at maximum output frequency.
// R9: analog level equals gain times standard output plus offset.
// R10: offset 100 % equals full 10 V / 20 mA; range -100..100 %, reset 0.
// R11: gain range -10.00..10.00, reset 1.00, may invert the curve.
// R12: standard analog output spans full range for 0..100 % source.
// R13: each switched output has its own 0..3600.0 s delay, reset 0.
// R14: polarity word holds five decimal digits, one per switched output.
// R15: digit 0 closes terminal to common return while function active.
// R16: digit 1 inverts: terminal open while active, closed while inactive.
// R17: corrected analog level is clamped to the physical range.
// R18: a reversal before the delay expires restarts the delay.
`timescale 1ns/10ps
`default_nettype none
`include "doc_defs.svh"

module doc_top #(
  parameter int unsigned DLY_TICK_CYC = `DOC_DLY_UNIT_NS / `DOC_CLK_PERIOD_NS,
  parameter int unsigned PF_HALF_CYC = `DOC_CLK_HZ / (`DOC_PF_STEP_HZ * 2)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive quantities
  input wire logic [15:0] run_freq,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] out_current,
  input wire logic [15:0] out_torque,
  input wire logic [15:0] out_power,
  input wire logic [15:0] out_voltage,
  input wire logic [15:0] pulse_in_freq,
  input wire logic [15:0] analog_in_1,
  input wire logic [15:0] analog_in_2,
  input wire logic [15:0] analog_in_3,
  input wire logic [15:0] length_value,
  input wire logic [15:0] count_value,
  input wire logic [15:0] comm_value,
  input wire logic [15:0] motor_speed,
  // full-scale references
  input wire logic [15:0] max_out_freq,
  input wire logic [15:0] rated_current,
  input wire logic [15:0] rated_torque,
  input wire logic [15:0] rated_power,
  input wire logic [15:0] rated_voltage,
  input wire logic [15:0] max_length,
  input wire logic [15:0] max_count,
  input wire logic [15:0] max_speed,
  // switched output functions, active high
  input wire logic [4:0] func_active,
  // terminals
  output logic pulse_terminal,
  output logic [16:0] analog_out_1,
  output logic [16:0] analog_out_2,
  output logic open_collector_output,
  output logic relay_1_closed,
  output logic relay_2_closed,
  output logic digital_out_1,
  output logic digital_out_2
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] fn_digit(input logic [15:0] v,
                                          input int unsigned n);
    int unsigned p;
    p = 1;
    for (int i = 0; i < 5; i++) begin
      if (i < n) begin
        p = p * 10;
      end
    end
    return 4'((32'(v) / p) % 10);
  endfunction : fn_digit

  function automatic logic fn_in_sym(input logic [15:0] v,
                                     input logic [15:0] lim);
    return ($signed(v) <= $signed(lim)) && ($signed(v) >= -$signed(lim));
  endfunction : fn_in_sym

  function automatic logic fn_write_ok(input logic [3:0] ix,
                                       input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    if (ix <= `DOC_IX_AO2_SRC) begin
      ok = (v <= `DOC_SRC_MAX);
    end else if (ix == `DOC_IX_PF_MAX) begin
      ok = (v >= `DOC_PF_MIN) && (v <= `DOC_PF_LIMIT); // R2
    end else if (ix <= `DOC_IX_AO2_GAIN) begin
      ok = fn_in_sym(v, `DOC_COEF_LIMIT); // R10 R11
    end else if (ix <= `DOC_IX_DLY_LAST) begin
      ok = (v <= `DOC_DLY_LIMIT); // R13
    end else if (ix == `DOC_IX_POLARITY) begin
      for (int i = 0; i < 5; i++) begin
        ok = ok && (fn_digit(v, i) <= 4'h1); // R14
      end
    end else begin
      ok = 1'b0;
    end
    return ok;
  endfunction : fn_write_ok

  function automatic logic [15:0] fn_reset_val(input int unsigned ix);
    logic [15:0] v;
    v = `DOC_RST_ZERO;
    if (4'(ix) == `DOC_IX_AO2_SRC) begin
      v = `DOC_RST_AO2_SRC;
    end else if (4'(ix) == `DOC_IX_PF_MAX) begin
      v = `DOC_RST_PF_MAX; // R2
    end else if (4'(ix) == `DOC_IX_AO1_GAIN || 4'(ix) == `DOC_IX_AO2_GAIN) begin
      v = `DOC_RST_GAIN; // R11
    end
    return v;
  endfunction : fn_reset_val

  // level in 0.001 % of full scale: 0.01 gain * 0.1 % source
  function automatic logic [16:0] fn_ao(input logic [10:0] pct,
                                        input logic [15:0] gain,
                                        input logic [15:0] ofs);
    logic signed [31:0] y;
    y = $signed({{16{gain[15]}}, gain}) * $signed({21'h0, pct})
        + $signed({{16{ofs[15]}}, ofs}) * $signed(`DOC_OFS_SCALE); // R9 R10
    if (y < 0) begin
      y = 0; // R17
    end else if (y > $signed(`DOC_AO_FULL)) begin
      y = $signed(`DOC_AO_FULL); // R17
    end
    return y[16:0];
  endfunction : fn_ao

  // ==========================================================
  // apb register file
  doc_pkg::doc_word_t cfg_q [0:`DOC_NUM_CFG-1];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [3:0] ix;
  logic mapped;
  logic setup;
  logic access;
  logic [13:0] pf_freq_q;
  logic [4:0] shown_q;
  logic [4:0] term_q;

  assign ix = paddr[5:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // answer is prepared in the setup cycle so that data leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= !mapped;
      if (mapped && pwrite) begin
        pslverr_q <= !fn_write_ok(ix, pwdata[15:0]);
      end else if (mapped && ix == `DOC_IX_PF_STATUS) begin
        prdata_q <= {18'h0, pf_freq_q};
      end else if (mapped && ix == `DOC_IX_SW_STATUS) begin
        prdata_q <= {19'h0, term_q, 3'h0, shown_q};
      end else if (mapped) begin
        prdata_q <= {16'h0, cfg_q[ix]};
      end
    end
  end

  // out-of-range writes are refused and leave the old setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `DOC_NUM_CFG; i++) begin
        cfg_q[i] <= fn_reset_val(i);
      end
    end else if (access && pwrite && mapped && !pslverr_q) begin
      cfg_q[ix] <= pwdata[15:0];
    end
  end

  // ==========================================================
  // source scaling: one shared divider serves four jobs in turn
  doc_pkg::doc_state_t state_q;
  logic [1:0] job_q;
  logic [31:0] rem_q;
  logic [31:0] quo_q;
  logic [31:0] den_q;
  logic [5:0] step_q;
  logic [10:0] pct_q [0:2];
  logic [15:0] src;
  logic [31:0] num;
  logic [31:0] den;
  logic signed [31:0] tq_shift;
  logic [15:0] tq_abs;
  logic [32:0] rem_sh;

  always_comb begin
    src = cfg_q[job_q == 2'h3 ? 2'h0 : job_q];
    tq_abs = out_torque[15] ? 16'(-out_torque) : out_torque;
    tq_shift = $signed({{16{out_torque[15]}}, out_torque})
               + $signed({15'h0, rated_torque, 1'b0});
    num = 32'h0;
    den = 32'h0;
    unique case (src)
      16'h0000: begin num = {16'h0, run_freq}; den = {16'h0, max_out_freq}; end // R3
      16'h0001: begin num = {16'h0, set_freq}; den = {16'h0, max_out_freq}; end // R3
      16'h0002: begin num = {16'h0, out_current}; den = {15'h0, rated_current, 1'b0}; end // R4
      16'h0003: begin num = {16'h0, tq_abs}; den = {15'h0, rated_torque, 1'b0}; end // R4
      16'h0004: begin num = {16'h0, out_power}; den = {15'h0, rated_power, 1'b0}; end // R4
      16'h0005: begin
        num = 32'({16'h0, out_voltage} * 32'h5); // R5
        den = 32'({16'h0, rated_voltage} * 32'h6);
      end
      16'h0006: begin num = {16'h0, pulse_in_freq}; den = `DOC_FS_PULSE_IN; end
      16'h0007: begin num = {16'h0, analog_in_1}; den = `DOC_FS_AIN; end
      16'h0008: begin num = {16'h0, analog_in_2}; den = `DOC_FS_AIN; end
      16'h0009: begin num = {16'h0, analog_in_3}; den = `DOC_FS_AIN; end
      16'h000A: begin num = {16'h0, length_value}; den = {16'h0, max_length}; end // R7
      16'h000B: begin num = {16'h0, count_value}; den = {16'h0, max_count}; end // R7
      16'h000C: begin num = {16'h0, comm_value}; den = `DOC_PCT_FULL; end
      16'h000D: begin num = {16'h0, motor_speed}; den = {16'h0, max_speed}; end // R8
      16'h000E: begin num = {16'h0, out_current}; den = `DOC_FS_CURRENT_A; end // R6
      16'h000F: begin num = {16'h0, out_voltage}; den = `DOC_FS_VOLT_V; end
      16'h0010: begin
        num = tq_shift[31] ? 32'h0 : tq_shift; // R6
        den = {14'h0, rated_torque, 2'h0};
      end
      default: begin num = 32'h0; den = 32'h0; end
    endcase
    if (job_q == 2'h3) begin
      // pulse rate = min + pct * (max - min), in 0.01 kHz
      num = 32'({21'h0, pct_q[0]} * {16'h0, cfg_q[`DOC_IX_PF_MAX] - 16'h1}); // R1
      den = `DOC_PCT_FULL;
    end else begin
      num = 32'(num * `DOC_PCT_FULL);
    end
    rem_sh = {rem_q, quo_q[31]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= doc_pkg::ST_LOAD;
      job_q <= 2'h0;
      rem_q <= 32'h0;
      quo_q <= 32'h0;
      den_q <= 32'h0;
      step_q <= 6'h0;
    end else begin
      unique case (state_q)
        doc_pkg::ST_LOAD: begin
          rem_q <= 32'h0;
          quo_q <= num;
          den_q <= den;
          step_q <= 6'h0;
          state_q <= doc_pkg::ST_DIV;
        end
        doc_pkg::ST_DIV: begin
          if ({1'b0, den_q} <= rem_sh) begin
            rem_q <= 32'(rem_sh - {1'b0, den_q});
            quo_q <= {quo_q[30:0], 1'b1};
          end else begin
            rem_q <= rem_sh[31:0];
            quo_q <= {quo_q[30:0], 1'b0};
          end
          step_q <= step_q + 6'h1;
          if (step_q == `DOC_DIV_STEPS - 6'h1) begin
            state_q <= doc_pkg::ST_STORE;
          end
        end
        doc_pkg::ST_STORE: begin
          job_q <= job_q + 2'h1;
          state_q <= doc_pkg::ST_LOAD;
        end
      endcase
    end
  end

  // a zero full-scale reference reads as 0 %; above full scale saturates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        pct_q[i] <= 11'h0;
      end
      pf_freq_q <= 14'h1;
    end else if (state_q == doc_pkg::ST_STORE) begin
      if (job_q == 2'h3) begin
        pf_freq_q <= 14'(quo_q + 32'h1); // R1
      end else if (den_q == 32'h0) begin
        pct_q[job_q] <= 11'h0;
      end else if (quo_q > `DOC_PCT_FULL) begin
        pct_q[job_q] <= `DOC_PCT_SAT; // R3
      end else begin
        pct_q[job_q] <= quo_q[10:0]; // R3
      end
    end
  end

  // ==========================================================
  // analog outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_out_1 <= 17'h0;
      analog_out_2 <= 17'h0;
    end else begin
      analog_out_1 <= fn_ao(pct_q[1], cfg_q[`DOC_IX_AO1_GAIN],
                            cfg_q[`DOC_IX_AO1_OFS]); // R9 R12
      analog_out_2 <= fn_ao(pct_q[2], cfg_q[`DOC_IX_AO2_GAIN],
                            cfg_q[`DOC_IX_AO2_OFS]); // R9 R12
    end
  end

  // ==========================================================
  // pulse output: phase accumulator, one step per 10 Hz of rate
  logic [21:0] pf_acc_q;
  logic [21:0] pf_acc_nx;

  assign pf_acc_nx = pf_acc_q + {8'h0, pf_freq_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_acc_q <= 22'h0;
      pulse_terminal <= 1'b0;
    end else if (pf_acc_nx >= 22'(PF_HALF_CYC)) begin
      pf_acc_q <= pf_acc_nx - 22'(PF_HALF_CYC); // R1
      pulse_terminal <= !pulse_terminal;
    end else begin
      pf_acc_q <= pf_acc_nx;
    end
  end

  // ==========================================================
  // switched outputs: delay then polarity
  // the 0.1 s tick is shared, so a delay may run up to one tick short
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [15:0] dly_cnt_q [0:4];

  assign tick = (tick_cnt_q == DLY_TICK_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shown_q <= 5'h0;
      for (int i = 0; i < 5; i++) begin
        dly_cnt_q[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (func_active[i] == shown_q[i]) begin
          dly_cnt_q[i] <= 16'h0; // R18
        end else if (dly_cnt_q[i] >= cfg_q[`DOC_IX_DLY_FIRST + 4'(i)]) begin
          shown_q[i] <= func_active[i]; // R13
          dly_cnt_q[i] <= 16'h0;
        end else if (tick) begin
          dly_cnt_q[i] <= dly_cnt_q[i] + 16'h1; // R13
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_q <= 5'h0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        // conduct when active, or when inactive if inverted
        term_q[i] <= shown_q[i]
                     ^ (fn_digit(cfg_q[`DOC_IX_POLARITY], i) == 4'h1); // R14 R15 R16
      end
    end
  end

  assign open_collector_output = term_q[0];
  assign relay_1_closed = term_q[1];
  assign relay_2_closed = term_q[2];
  assign digital_out_1 = term_q[3];
  assign digital_out_2 = term_q[4];

endmodule : doc_top

`default_nettype wire

// ---- verification/doc_sva.sv ----
/*
  checker for doc_top: setting range refusals, analog level limits and
  switched terminal state after reset; bound to doc_top at the foot.
  assumes doc_defs.svh on the include path and one pclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "doc_defs.svh"
module doc_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // terminals
  input wire logic [16:0] analog_out_1,
  input wire logic [16:0] analog_out_2,
  input wire logic open_collector_output
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ws;
  logic [15:0] v;
  logic coef_bad;
  assign ws = psel && !penable && pwrite;
  assign v = pwdata[15:0];
  // signed compare, so settings below the negative limit count too
  assign coef_bad = $signed(v) > $signed(`DOC_COEF_LIMIT) ||
    $signed(v) < -$signed(`DOC_COEF_LIMIT);
  // ==========================================================
  // assertions
  AST_SRC_RANGE:
    assert property (ws && paddr < 8'h0C && v > `DOC_SRC_MAX |=> pslverr)
    else $error("source code above range accepted");
  AST_PF_MAX_RANGE:
    assert property (ws && paddr == 8'h0C &&
      (v < `DOC_PF_MIN || v > `DOC_PF_LIMIT) |=> pslverr)
    else $error("pulse maximum out of range accepted");
  AST_OFS_RANGE:
    assert property (ws && (paddr == 8'h10 || paddr == 8'h18) && coef_bad
      |=> pslverr)
    else $error("offset out of range accepted");
  AST_GAIN_RANGE:
    assert property (ws && (paddr == 8'h14 || paddr == 8'h1C) && coef_bad
      |=> pslverr)
    else $error("gain out of range accepted");
  AST_DLY_RANGE:
    assert property (ws && paddr inside {[8'h20:8'h30]} &&
      v > `DOC_DLY_LIMIT |=> pslverr)
    else $error("delay out of range accepted");
  AST_POL_RANGE:
    assert property (ws && paddr == 8'h34 && v > 16'h2B67 |=> pslverr)
    else $error("polarity word out of range accepted");
  AST_AO1_FULL:
    assert property (analog_out_1 <= 17'h186A0)
    else $error("analog output 1 above full scale");
  AST_AO2_CLAMP:
    assert property (analog_out_2 <= 17'h186A0)
    else $error("analog output 2 above full scale");
  AST_RESET_OPEN:
    assert property ($rose(presetn) |-> !open_collector_output [*2])
    else $error("terminal conducting right after reset");
  // ==========================================================
  // covers
  COV_REFUSED: cover property (ws ##1 pslverr);
  COV_AO_FULL: cover property (analog_out_1 == 17'h186A0);
  COV_OC_ON: cover property ($rose(open_collector_output));
endmodule : doc_sva

bind doc_top doc_sva doc_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .analog_out_1, .analog_out_2,
  .open_collector_output);
`default_nettype wire

// ---- verification/doc_meter.sv ----
/*
  far-side meter on the pulse terminal: reports the last half period in
  pclk cycles. assumes the terminal is sampled on pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module doc_meter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // terminal and reading
  input wire logic pulse,
  output logic [15:0] half_cyc
);
  // ==========================================================
  // edge to edge count; saturates, but the reading changes only at an edge, so a stuck terminal keeps its last reading
  logic prev_q;
  logic [15:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      cnt_q <= 16'h0000;
      half_cyc <= 16'h0000;
    end else begin
      prev_q <= pulse;
      if (pulse != prev_q) begin
        half_cyc <= cnt_q + 16'h0001;
        cnt_q <= 16'h0000;
      end else if (cnt_q != 16'hFFFF) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule : doc_meter
`default_nettype wire

// ---- verification/doc_top_bench.sv ----
/*
  self-checking bench for doc_top: registers over apb, source scaling,
  gain/offset, pulse rate, switched delay and polarity.
  assumes doc_sva and doc_meter compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module doc_top_bench;
  // ==========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] run_freq, set_freq, out_current, out_torque, out_power;
  logic [15:0] out_voltage, pulse_in_freq, analog_in_1, analog_in_2;
  logic [15:0] analog_in_3, length_value, count_value, comm_value;
  logic [15:0] motor_speed, max_out_freq, rated_current, rated_torque;
  logic [15:0] rated_power, rated_voltage, max_length, max_count;
  logic [15:0] max_speed, half;
  logic [4:0] func_active, sw;
  logic [16:0] analog_out_1, analog_out_2;
  logic pulse_terminal, open_collector_output, relay_1_closed;
  logic relay_2_closed, digital_out_1, digital_out_2;
  int n_errors = 0;
  int checks_done = 0;
  logic [15:0] rst_v [14] = '{16'h0, 16'h0, 16'h1, 16'h1388, 16'h0,
    16'h64, 16'h0, 16'h64, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  assign sw = {digital_out_2, digital_out_1, relay_2_closed,
    relay_1_closed, open_collector_output};

  // short tick and pulse base keep delays and periods to a few cycles
  doc_top #(.DLY_TICK_CYC(10), .PF_HALF_CYC(200)) doc_top_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .run_freq, .set_freq, .out_current, .out_torque, .out_power,
    .out_voltage, .pulse_in_freq, .analog_in_1, .analog_in_2, .analog_in_3,
    .length_value, .count_value, .comm_value, .motor_speed, .max_out_freq,
    .rated_current, .rated_torque, .rated_power, .rated_voltage,
    .max_length, .max_count, .max_speed, .func_active, .pulse_terminal,
    .analog_out_1, .analog_out_2, .open_collector_output, .relay_1_closed,
    .relay_2_closed, .digital_out_1, .digital_out_2);
  doc_meter doc_meter_i (.clk(pclk), .rst_n(presetn),
    .pulse(pulse_terminal), .half_cyc(half));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic xe);
    apb(1'b1, a, d);
    chk(32'(e), 32'(xe));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd

  task automatic ao(input logic [31:0] g, input logic [31:0] o,
    input logic [31:0] x);
    wr(8'h14, g, 1'b0);
    wr(8'h10, o, 1'b0);
    repeat (400) @(posedge pclk);
    chk(32'(analog_out_1), x);
  endtask : ao

  task automatic pf(input logic [15:0] f, input int h);
    run_freq <= f;
    repeat (1000) @(posedge pclk);
    chk(32'(half >= h - 1 && half <= h + 1), 32'h1);
  endtask : pf

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  // ==========================================================
  // tests
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; func_active = 5'h00;
    run_freq = 16'h01F4; set_freq = 16'h01F4; out_current = 16'h1388;
    out_torque = 16'h03E8; out_power = 16'h0190; out_voltage = 16'h1770;
    pulse_in_freq = 16'h1388; analog_in_1 = 16'h01F4;
    analog_in_2 = 16'h01F4; analog_in_3 = 16'h01F4;
    length_value = 16'h012C; count_value = 16'h0064;
    comm_value = 16'h01F4; motor_speed = 16'h02BC; max_out_freq = 16'h03E8;
    rated_current = 16'h1388; rated_torque = 16'h03E8;
    rated_power = 16'h0190; rated_voltage = 16'h2710;
    max_length = 16'h0258; max_count = 16'h00C8; max_speed = 16'h0578;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 14; i++) rd(8'(i * 4), {16'h0, rst_v[i]});
    apb(1'b0, 8'h40, 32'h0);
    chk({r[31:1], e}, 32'h1);
    wr(8'h38, 32'h1, 1'b1);
    $display("test reset done");
    wr(8'h0C, 32'h0, 1'b1);
    wr(8'h0C, 32'h2711, 1'b1);
    rd(8'h0C, 32'h1388);
    wr(8'h0C, 32'h2710, 1'b0);
    rd(8'h0C, 32'h2710);
    wr(8'h00, 32'h11, 1'b1);
    wr(8'h10, 32'hFC17, 1'b1);
    wr(8'h14, 32'h03E9, 1'b1);
    wr(8'h14, 32'hFC18, 1'b0);
    rd(8'h14, 32'hFC18);
    wr(8'h14, 32'h0064, 1'b0);
    wr(8'h20, 32'h8CA1, 1'b1);
    wr(8'h20, 32'h8CA0, 1'b0);
    wr(8'h34, 32'h0002, 1'b1);
    $display("test ranges done");
    // every input sits at half its full scale except codes 15 and 16
    for (int c = 0; c <= 16; c++) begin
      wr(8'h04, 32'(c), 1'b0);
      repeat (400) @(posedge pclk);
      chk(32'(analog_out_1), c == 15 ? 32'h0EA60 : c == 16 ? 32'h124F8 :
        32'h0C350);
    end
    chk(32'(analog_out_2), 32'h0C350);
    $display("test sources done");
    wr(8'h04, 32'h0, 1'b0);
    ao(32'hFFCE, 32'h0320, 32'h0D6D8);
    ao(32'h03E8, 32'h0, 32'h186A0);
    ao(32'h0064, 32'hFC18, 32'h0);
    ao(32'h0, 32'h03E8, 32'h186A0);
    $display("test correction done");
    // the short pulse base lets the accumulator run away at high rates,
    // so a mid-run reset clears it before the low maximum is set
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wr(8'h0C, 32'h0028, 1'b0);
    pf(16'h0000, 200);
    pf(16'h03E8, 5);
    rd(8'h38, 32'h0000_0028);
    $display("test pulse done");
    wr(8'h20, 32'h0003, 1'b0);
    func_active <= 5'h01;
    repeat (15) @(posedge pclk);
    chk(32'(sw), 32'h0);
    repeat (30) @(posedge pclk);
    chk(32'(sw), 32'h1);
    // two short drops: without a restart their time would add up
    func_active <= 5'h00;
    repeat (15) @(posedge pclk);
    func_active <= 5'h01;
    repeat (2) @(posedge pclk);
    func_active <= 5'h00;
    repeat (15) @(posedge pclk);
    chk(32'(sw), 32'h1);
    repeat (30) @(posedge pclk);
    chk(32'(sw), 32'h0);
    func_active <= 5'h01;
    wr(8'h20, 32'h0, 1'b0);
    wr(8'h34, 32'h2B67, 1'b0);
    repeat (4) @(posedge pclk);
    chk(32'(sw), 32'h1E);
    wr(8'h34, 32'h2775, 1'b0);
    repeat (4) @(posedge pclk);
    chk(32'(sw), 32'h14);
    rd(8'h3C, 32'h0000_1401);
    $display("test switched done");
    conclude();
  end
endmodule : doc_top_bench
`default_nettype wire
